// ### core/fbp_flash.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 512 blocks of 64 bytes, index 0-511
// - programming always writes one whole block
// - reads are single bytes at any address
// - each block keeps its own protection level
// - level 0: all reads and writes allowed
// - level 1: external reads refused, writes allowed
// - level 2: only internal reads and writes allowed
// - level 3: all writes refused
// - firmware cannot change protection levels
module fbp_flash
    import fbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fbp_req_s int_req,
    output fbp_rsp_s int_rsp,
    input wire fbp_req_s ext_req,
    output fbp_rsp_s ext_rsp
);
    typedef enum {
        FBP_IDLE,
        FBP_FILL
    } fbp_state_e;

    logic [7:0] mem_reg [FBP_MEM_BYTES];
    logic [1:0] level_reg [FBP_NUM_BLOCKS];
    fbp_state_e int_state_reg, ext_state_reg;
    logic [FBP_BYTE_AW-1:0] int_cnt_reg, ext_cnt_reg;
    logic [FBP_BLK_AW-1:0] int_blk_reg, ext_blk_reg;
    logic int_ok_reg, ext_ok_reg;
    fbp_rsp_s int_rsp_reg, ext_rsp_reg;

    logic [FBP_BLK_AW-1:0] int_blk, ext_blk;
    fbp_level_e int_lvl, ext_lvl, int_wlvl, ext_wlvl;
    logic int_rd_ok, ext_rd_ok, int_wr_ok, ext_wr_ok;
    logic int_we, ext_we;
    logic int_first, ext_first;
    logic [FBP_BLK_AW-1:0] int_wblk, ext_wblk;
    logic [FBP_BYTE_AW-1:0] int_wofs, ext_wofs;

    assign int_blk = int_req.addr[FBP_ADDR_W-1:FBP_BYTE_AW];
    assign ext_blk = ext_req.addr[FBP_ADDR_W-1:FBP_BYTE_AW];
    assign int_lvl = fbp_level_e'(level_reg[int_blk]);
    assign ext_lvl = fbp_level_e'(level_reg[ext_blk]);
    // byte 0 is stored on the edge that opens the block, so on that edge
    // the block comes from the request and the offset is forced to zero
    assign int_first = (int_state_reg == FBP_IDLE);
    // a level write outranks a block write on the programming port
    assign ext_first = (ext_state_reg == FBP_IDLE) && !ext_req.lvl_wr;
    assign int_wblk = int_first ? int_blk : int_blk_reg;
    assign ext_wblk = ext_first ? ext_blk : ext_blk_reg;
    assign int_wofs = int_first ? '0 : int_cnt_reg;
    assign ext_wofs = ext_first ? '0 : ext_cnt_reg;
    // guard follows the stored level, so a level change mid-block counts
    assign int_wlvl = fbp_level_e'(level_reg[int_wblk]);
    assign ext_wlvl = fbp_level_e'(level_reg[ext_wblk]);

    // internal reads are never refused, whatever the level
    assign int_rd_ok = 1'b1;
    assign ext_rd_ok = (ext_lvl == FBP_LVL_OPEN);
    assign int_wr_ok = (int_wlvl != FBP_LVL_FULL);
    assign ext_wr_ok = (ext_wlvl == FBP_LVL_OPEN)
        || (ext_wlvl == FBP_LVL_FACTORY);

    // a block write streams 64 bytes; a refused one consumes them unstored
    assign int_we = int_req.wr && int_wr_ok;
    assign ext_we = ext_req.wr && ext_wr_ok
        && (ext_first || (ext_state_reg == FBP_FILL));

    // programming port wins if both ports hit the same byte
    always_ff @(posedge clk)
    begin
        if (int_we)
        begin
            mem_reg[{int_wblk, int_wofs}] <= int_req.wdata;
        end
        if (ext_we)
        begin
            mem_reg[{ext_wblk, ext_wofs}] <= ext_req.wdata;
        end
    end

    // only the programming port has a level write path
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            // unprogrammed blocks come up fully locked
            for (int i = 0; i < FBP_NUM_BLOCKS; i++)
            begin
                level_reg[i] <= FBP_LEVEL_RESET;
            end
        end
        else if (ext_req.lvl_wr && ext_state_reg == FBP_IDLE)
        begin
            level_reg[ext_blk] <= ext_req.level;
        end
    end

    // cpu port: every answer is registered one edge after its request
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            int_state_reg <= FBP_IDLE;
            int_cnt_reg <= '0;
            int_blk_reg <= '0;
            int_ok_reg <= 1'b0;
            int_rsp_reg <= '0;
        end
        else
        begin
            int_rsp_reg.done <= 1'b0;
            case (int_state_reg)
                FBP_IDLE:
                begin
                    if (int_req.wr)
                    begin
                        // byte 0 is stored now; its offset bits are ignored
                        int_blk_reg <= int_blk;
                        int_cnt_reg <= 6'h01;
                        int_ok_reg <= (int_lvl != FBP_LVL_FULL);
                        int_state_reg <= FBP_FILL;
                    end
                    else if (int_req.rd)
                    begin
                        int_rsp_reg.done <= 1'b1;
                        int_rsp_reg.ok <= int_rd_ok;
                        int_rsp_reg.rdata <= mem_reg[int_req.addr];
                    end
                end
                FBP_FILL:
                begin
                    // wr low stalls the count and stores nothing
                    if (int_req.wr)
                    begin
                        int_cnt_reg <= int_cnt_reg + 6'h01;
                        if (int_cnt_reg == 6'h3f)
                        begin
                            int_rsp_reg.done <= 1'b1;
                            int_rsp_reg.ok <= int_ok_reg;
                            int_rsp_reg.rdata <= '0;
                            int_state_reg <= FBP_IDLE;
                        end
                    end
                end
                default: int_state_reg <= FBP_IDLE;
            endcase
        end
    end

    // programming port: same timing as the cpu port, plus level writes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ext_state_reg <= FBP_IDLE;
            ext_cnt_reg <= '0;
            ext_blk_reg <= '0;
            ext_ok_reg <= 1'b0;
            ext_rsp_reg <= '0;
        end
        else
        begin
            ext_rsp_reg.done <= 1'b0;
            case (ext_state_reg)
                FBP_IDLE:
                begin
                    if (ext_req.lvl_wr)
                    begin
                        ext_rsp_reg.done <= 1'b1;
                        ext_rsp_reg.ok <= 1'b1;
                        ext_rsp_reg.rdata <= '0;
                    end
                    else if (ext_req.wr)
                    begin
                        // byte 0 is stored now; its offset bits are ignored
                        ext_blk_reg <= ext_blk;
                        ext_cnt_reg <= 6'h01;
                        ext_ok_reg <= (ext_lvl == FBP_LVL_OPEN)
                            || (ext_lvl == FBP_LVL_FACTORY);
                        ext_state_reg <= FBP_FILL;
                    end
                    else if (ext_req.rd)
                    begin
                        ext_rsp_reg.done <= 1'b1;
                        ext_rsp_reg.ok <= ext_rd_ok;
                        // refused reads return zero, never array contents
                        ext_rsp_reg.rdata <= ext_rd_ok
                            ? mem_reg[ext_req.addr] : 8'h00;
                    end
                end
                FBP_FILL:
                begin
                    // wr low stalls the count and stores nothing
                    if (ext_req.wr)
                    begin
                        ext_cnt_reg <= ext_cnt_reg + 6'h01;
                        if (ext_cnt_reg == 6'h3f)
                        begin
                            ext_rsp_reg.done <= 1'b1;
                            ext_rsp_reg.ok <= ext_ok_reg;
                            ext_rsp_reg.rdata <= '0;
                            ext_state_reg <= FBP_IDLE;
                        end
                    end
                end
                default: ext_state_reg <= FBP_IDLE;
            endcase
        end
    end

    // ok and rdata hold until the next done pulse
    assign int_rsp = int_rsp_reg;
    assign ext_rsp = ext_rsp_reg;
endmodule
`default_nettype wire

// ### core/fbp_pkg.sv
package fbp_pkg;
    localparam int unsigned FBP_BLOCK_BYTES = 64;
    localparam int unsigned FBP_NUM_BLOCKS = 512;
    localparam int unsigned FBP_BYTE_AW = 6;
    localparam int unsigned FBP_BLK_AW = 9;
    localparam int unsigned FBP_ADDR_W = 15;
    localparam int unsigned FBP_MEM_BYTES = 32768;
    localparam logic [1:0] FBP_LEVEL_RESET = 2'h3;
    localparam logic [7:0] FBP_DATA_RESET = 8'hff;

    typedef enum logic [1:0] {
        FBP_LVL_OPEN,
        FBP_LVL_FACTORY,
        FBP_LVL_FIELD,
        FBP_LVL_FULL
    } fbp_level_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic lvl_wr;
        logic [14:0] addr;
        logic [7:0] wdata;
        logic [1:0] level;
    } fbp_req_s;

    typedef struct packed {
        logic done;
        logic ok;
        logic [7:0] rdata;
    } fbp_rsp_s;
endpackage

// ### test/fbp_flash_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_sva
    import fbp_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire fbp_req_s int_req,
    input wire fbp_rsp_s int_rsp,
    input wire fbp_req_s ext_req,
    input wire fbp_rsp_s ext_rsp
);
    logic [1:0] lvl_reg [512];
    logic [5:0] ecnt_reg;
    logic [5:0] icnt_reg;
    logic [1:0] elvl;
    logic [1:0] ilvl;
    assign elvl = lvl_reg[ext_req.addr[14:6]];
    assign ilvl = lvl_reg[int_req.addr[14:6]];
    always_ff @(posedge clk)
        if (rst)
            lvl_reg <= '{default: 2'h3};
        else if (ext_req.lvl_wr)
            lvl_reg[ext_req.addr[14:6]] <= ext_req.level;
    // byte counters wrap at 64, so a block always ends on 6'h3f
    always_ff @(posedge clk)
        if (rst)
            ecnt_reg <= 6'h0;
        else if (ext_req.wr)
            ecnt_reg <= ecnt_reg + 6'h1;
    always_ff @(posedge clk)
        if (rst)
            icnt_reg <= 6'h0;
        else if (int_req.wr)
            icnt_reg <= icnt_reg + 6'h1;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_ext_last; ext_req.wr && ecnt_reg == 6'h3f; endsequence
    sequence s_int_last; int_req.wr && icnt_reg == 6'h3f; endsequence
    AST_EXT_BLK: assert property (s_ext_last |=>
        ext_rsp.done && ext_rsp.ok == ($past(elvl) < 2'h2)) else $error("ext blk");
    AST_INT_BLK: assert property (s_int_last |=>
        int_rsp.done && int_rsp.ok == ($past(ilvl) != 2'h3)) else $error("int blk");
    AST_BLK_EARLY: assert property (ext_req.wr && ecnt_reg != 6'h3f |=>
        !ext_rsp.done) else $error("early done");
    AST_EXT_RD: assert property (ext_req.rd && !ext_req.wr && !ext_req.lvl_wr |=>
        ext_rsp.done && ext_rsp.ok == ($past(elvl) == 2'h0)) else $error("ext rd");
    AST_EXT_RD_ZERO: assert property (ext_rsp.done && !ext_rsp.ok &&
        $past(ext_req.rd) |-> ext_rsp.rdata == 8'h00) else $error("rdata leak");
    AST_INT_RD: assert property (int_req.rd && !int_req.wr && !int_req.lvl_wr |=>
        int_rsp.done && int_rsp.ok) else $error("int rd");
    AST_LVL_ACK: assert property (ext_req.lvl_wr |=>
        ext_rsp.done && ext_rsp.ok) else $error("lvl ack");
    AST_INT_LVL: assert property (int_req.lvl_wr && !int_req.wr && !int_req.rd |=>
        !int_rsp.done) else $error("int lvl");
endmodule
bind fbp_flash fbp_flash_sva fbp_flash_sva_inst(.clk(clk), .rst(rst),
    .int_req(int_req), .int_rsp(int_rsp), .ext_req(ext_req), .ext_rsp(ext_rsp));
`default_nettype wire

// ### test/fbp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module fbp_prog_model
    import fbp_pkg::*;
(
    input wire logic clk,
    output fbp_req_s int_req,
    output fbp_req_s ext_req,
    input wire fbp_rsp_s int_rsp,
    input wire fbp_rsp_s ext_rsp
);
    fbp_rsp_s rsp;
    initial
    begin
        int_req = '0;
        ext_req = '0;
    end
    task automatic op(input logic ext, input fbp_req_s r, input int n);
        for (int k = 0; k < n; k++)
        begin
            @(posedge clk);
            if (ext)
                ext_req <= r;
            else
                int_req <= r;
            r.addr[5:0] = r.addr[5:0] + 6'h1;
            r.wdata = r.wdata + 8'h1;
        end
        @(posedge clk);
        ext_req <= '0;
        int_req <= '0;
        // the answer stands in the cycle after the last request edge
        @(posedge clk);
        rsp = ext ? ext_rsp : int_rsp;
    endtask
endmodule
`default_nettype wire

// ### test/tb_fbp_flash.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fbp_flash;
    import fbp_pkg::*;
    logic clk;
    logic rst;
    int errors;
    int num_checks;
    fbp_req_s int_req;
    fbp_req_s ext_req;
    fbp_rsp_s int_rsp;
    fbp_rsp_s ext_rsp;
    fbp_rsp_s r;
    fbp_flash fbp_flash_inst(.clk(clk), .rst(rst), .int_req(int_req),
        .int_rsp(int_rsp), .ext_req(ext_req), .ext_rsp(ext_rsp));
    fbp_prog_model fbp_prog_model_inst(.clk(clk), .int_req(int_req),
        .ext_req(ext_req), .int_rsp(int_rsp), .ext_rsp(ext_rsp));
    task automatic finish_test;
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1)
        begin
            errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // k: 4 read, 2 block write, 1 level write; d doubles as level
    task automatic go(input logic e, input logic [2:0] k,
        input logic [14:0] a, input logic [7:0] d, input int n);
        fbp_prog_model_inst.op(e, {k, a, d, d[1:0]}, n);
        r = fbp_prog_model_inst.rsp;
    endtask
    task automatic t_levels;
        logic [14:0] a;
        for (int l = 0; l < 4; l++)
        begin
            a = {9'(10 + l), 6'h0};
            go(1, 3'h1, a, 8'(l), 1);
            chk(r.done === 1 && r.ok === 1, "lvl");
            go(1, 3'h2, a, 8'h20, 64);
            chk(r.done === 1 && r.ok === (l < 2), "ext wr");
            go(1, 3'h4, a | 15'h3f, 8'h0, 1);
            chk(r.ok === (l == 0) && r.rdata === (l == 0 ? 8'h5f : 8'h0),
                "ext rd");
            go(0, 3'h2, a, 8'h80, 64);
            chk(r.done === 1 && r.ok === (l != 3), "int wr");
            go(0, 3'h4, a | 15'h3f, 8'h0, 1);
            chk(r.ok === 1 && (l == 3 || r.rdata === 8'hbf), "int rd");
        end
    endtask
    task automatic t_misc;
        logic [14:0] a;
        go(1, 3'h4, {9'd200, 6'h1}, 8'h0, 1);
        chk(r.done === 1 && r.ok === 0, "reset lvl");
        go(0, 3'h1, {9'd13, 6'h0}, 8'h0, 1);
        chk(r.done === 0, "fw lvl");
        go(1, 3'h4, {9'd13, 6'h0}, 8'h0, 1);
        chk(r.ok === 0, "lvl kept");
        for (int i = 0; i < 2; i++)
        begin
            a = i ? 15'h7fc0 : 15'h0;
            go(1, 3'h1, a, 8'h0, 1);
            go(1, 3'h2, a, 8'h01, 64);
            go(1, 3'h4, a + 15'h2a, 8'h0, 1);
            chk(r.ok === 1 && r.rdata === 8'h2b, "edge blk");
        end
    endtask
    initial
    begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        #500000;
        errors++;
        finish_test;
    end
    initial
    begin
        errors = 0;
        num_checks = 0;
        rst = 1;
        repeat (5) @(posedge clk);
        rst <= 0;
        t_levels;
        t_misc;
        finish_test;
    end
endmodule
`default_nettype wire
